/* File: src/asm_alarm_top.sv */
// Alarm status, mask and aggregation block with its register port
`timescale 1ns/1ps
module asm_alarm_top #(
	parameter int LANES = 8
) (
	input  wire logic                    mclk_in,
	input  wire logic                    reset_n_in,
	input  wire logic                    ce_in,
	input  wire logic [asm_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [asm_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic [asm_pkg::DATA_W-1:0]   rdata_out,
	input  wire logic                    pll_unlocked_in,
	input  wire logic                    payload_state_in,
	input  wire logic                    serdes_realign_in,
	input  wire logic                    sysref_realign_in,
	input  wire logic                    div_ab_ne_cd_in,
	input  wire logic [LANES-1:0]        lane_fifo_err_in,
	input  wire logic [LANES-1:0]        lane_active_in,
	input  wire logic                    cal_done_in,
	output logic                         alarm_irq_out,
	output logic                         cal_status_pin_out,
	output logic                         serial_link_enable_out
);
	// The lane register is LANES bits and must fit its one-byte read path
	if (LANES < 1 || LANES > 8) begin : g_bad_lanes
		$error("asm_alarm_top: LANES must be 1..8");
	end

	function automatic logic hit(input logic [asm_pkg::ADDR_W-1:0] a,
	                             input logic [asm_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	logic [7:0]       mask_reg;
	logic [7:0]       ctrl_reg;
	logic             soft_rst;
	logic             wr_status;
	logic             wr_lane;
	logic             link_alarm;
	logic             alarm_agg;
	logic [7:0]       status_set;
	logic [7:0]       rdata_next;
	logic [LANES-1:0] lane_set;

	asm_evt_if #(.W(8))     st_if ();
	asm_evt_if #(.W(LANES)) ln_if ();

	assign soft_rst  = ctrl_reg[asm_pkg::CTRL_SOFT_RST];
	assign wr_status = wr_in && hit(addr_in, asm_pkg::OFS_STATUS);
	assign wr_lane   = wr_in && hit(addr_in, asm_pkg::OFS_LANE);

	asm_link_mon u_link (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.ce_in      (ce_in),
		.link_en_in (ctrl_reg[asm_pkg::CTRL_LINK_EN]),
		.enc_64b_in (ctrl_reg[asm_pkg::CTRL_ENC_64B]),
		.payload_in (payload_state_in),
		.realign_in (serdes_realign_in),
		.alarm_out  (link_alarm)
	);

	// Per-lane alarms; a set still pending keeps the bit set through a clear in the same cycle
	assign lane_set  = lane_fifo_err_in;
	assign ln_if.set = lane_set;
	assign ln_if.clr = (wr_lane ? wdata_in[LANES-1:0] : '0)
	                 | ((wr_status && wdata_in[asm_pkg::BIT_FIFO]) ? {LANES{1'b1}} : '0);

	asm_w1c_reg #(.W(LANES), .RST(asm_pkg::LANE_RST)) u_lane (
		.mclk_in     (mclk_in),
		.reset_n_in  (reset_n_in),
		.ce_in       (ce_in),
		.soft_rst_in (soft_rst),
		.evt         (ln_if.owner)
	);

	always_comb begin
		status_set                      = 8'h00;
		status_set[asm_pkg::BIT_PLL]    = pll_unlocked_in;
		status_set[asm_pkg::BIT_LINK]   = link_alarm;
		status_set[asm_pkg::BIT_REALIGN] = sysref_realign_in;
		status_set[asm_pkg::BIT_CLK]    = div_ab_ne_cd_in;
		status_set[asm_pkg::BIT_FIFO]   = |(lane_fifo_err_in & lane_active_in);
	end

	assign st_if.set = status_set;
	// Reserved bits 1 and 7:6 keep their reset value; only alarm bits clear
	assign st_if.clr = wr_status ? (wdata_in & asm_pkg::STATUS_IMPL) : 8'h00;

	asm_w1c_reg #(.W(8), .RST(asm_pkg::STATUS_RST)) u_status (
		.mclk_in     (mclk_in),
		.reset_n_in  (reset_n_in),
		.ce_in       (ce_in),
		.soft_rst_in (soft_rst),
		.evt         (st_if.owner)
	);

	// Reserved mask bits are stored as written; software keeps them at reset value
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			mask_reg <= asm_pkg::MASK_RST;
		else if (ce_in) begin
			if (soft_rst)
				mask_reg <= asm_pkg::MASK_RST;
			else if (wr_in && hit(addr_in, asm_pkg::OFS_MASK))
				mask_reg <= wdata_in;
		end
	end

	// Soft reset bit is self-clearing after one cycle
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			ctrl_reg <= asm_pkg::CTRL_RST;
		else if (ce_in) begin
			if (wr_in && hit(addr_in, asm_pkg::OFS_CTRL))
				ctrl_reg <= wdata_in;
			else
				ctrl_reg[asm_pkg::CTRL_SOFT_RST] <= 1'b0;
		end
	end

	assign alarm_agg = |(st_if.q & ~mask_reg & asm_pkg::STATUS_IMPL);

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			alarm_irq_out      <= 1'b0;
			cal_status_pin_out <= 1'b0;
		end else if (ce_in) begin
			alarm_irq_out      <= alarm_agg;
			cal_status_pin_out <= ctrl_reg[asm_pkg::CTRL_PIN_SEL] ? alarm_agg : cal_done_in;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			serial_link_enable_out <= 1'b0;
		else if (ce_in)
			serial_link_enable_out <= ctrl_reg[asm_pkg::CTRL_LINK_EN];
	end

	always_comb begin
		rdata_next = 8'h00;
		case (addr_in)
			asm_pkg::OFS_ALARM:  rdata_next = {7'h00, alarm_agg};
			asm_pkg::OFS_STATUS: rdata_next = st_if.q;
			asm_pkg::OFS_MASK:   rdata_next = mask_reg;
			asm_pkg::OFS_LANE:   rdata_next = 8'(ln_if.q);
			asm_pkg::OFS_CTRL:   rdata_next = ctrl_reg;
			default:             rdata_next = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rdata_out <= 8'h00;
		else if (ce_in)
			rdata_out <= rd_in ? rdata_next : 8'h00;
	end
endmodule

/* File: src/asm_pkg.sv */
// Constants and types for the alarm status and mask logic
//
// Contract
// - Status bit 4 is set while the serializer PLL is out of lock.
// - In 8B/10B modes status bit 3 is set while the link is enabled but not in payload transfer state.
// - In 64B/66B modes status bit 3 is set at link start-up and on any lane FIFO or serializer realignment; only serdes_realign_in feeds it here.
// - Status bit 2 is set whenever SYSREF realigns the internal clocks.
// - Status bit 0 is set whenever the A/B clock dividers differ from the C/D dividers.
// - Writing one to a status bit clears it and writing zero leaves it alone.
// - Power-on reset or soft reset presets every alarm status bit to one.
// - Mask bits 5, 4, 3, 2 and 0 keep their alarm out of the aggregated bit, and all reset to one.
// - Per-lane FIFO alarm bit i is set when lane i FIFO overflows or underflows, resetting to all ones.
// - Writing one to a per-lane bit clears it, and it sets again at once if the condition persists.
// - Writing one to the summary FIFO bit clears the whole per-lane register.
// - Status bit 5 is set whenever any active lane FIFO overflows or underflows.
// - The read-only aggregated alarm bit is one while any unmasked status bit is set.
// - When routing selects it, the aggregated alarm drives the calibration status pin.
package asm_pkg;
	localparam int          ADDR_W         = 12;
	localparam int          DATA_W         = 8;
	localparam logic [11:0] OFS_ALARM      = 12'h2C0;
	localparam logic [11:0] OFS_STATUS     = 12'h2C1;
	localparam logic [11:0] OFS_MASK       = 12'h2C2;
	localparam logic [11:0] OFS_LANE       = 12'h2C4;
	localparam logic [11:0] OFS_CTRL       = 12'h2C6;
	localparam int          BIT_CLK        = 0;
	localparam int          BIT_REALIGN    = 2;
	localparam int          BIT_LINK       = 3;
	localparam int          BIT_PLL        = 4;
	localparam int          BIT_FIFO       = 5;
	localparam logic [7:0]  STATUS_RST     = 8'h3F;
	localparam logic [7:0]  STATUS_IMPL    = 8'h3D;
	localparam logic [7:0]  MASK_RST       = 8'h3F;
	localparam logic [7:0]  LANE_RST       = 8'hFF;
	localparam logic [7:0]  CTRL_RST       = 8'h00;
	localparam int          CTRL_LINK_EN   = 0;
	localparam int          CTRL_ENC_64B   = 1;
	localparam int          CTRL_PIN_SEL   = 2;
	localparam int          CTRL_SOFT_RST  = 7;

	typedef enum logic [1:0] {
		ASM_LINK_OFF  = 2'b00,
		ASM_LINK_UP   = 2'b01,
		ASM_LINK_DATA = 2'b10
	} asm_link_t;
endpackage

/* File: src/asm_evt_if.sv */
// Event bundle between the top and the alarm register cells
`timescale 1ns/1ps
interface asm_evt_if #(parameter int W = 8);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] q;
	modport owner (input set, input clr, output q);
	modport user  (output set, output clr, input q);
endinterface

/* File: src/asm_w1c_reg.sv */
// Sticky alarm bits with write-one clear and preset on reset
`timescale 1ns/1ps
module asm_w1c_reg #(
	parameter int         W   = 8,
	parameter logic [7:0] RST = 8'hFF
) (
	input  wire logic     mclk_in,
	input  wire logic     reset_n_in,
	input  wire logic     ce_in,
	input  wire logic     soft_rst_in,
	asm_evt_if.owner      evt
);
	// Widths above eight would not fit the reset constant
	if (W < 1 || W > 8) begin : g_bad_width
		$error("asm_w1c_reg: width must be 1..8");
	end

	logic [W-1:0] bits_reg;
	logic [W-1:0] bits_next;

	// Set is or-ed in after the clear so an event is never lost to a clear in the same cycle
	always_comb begin
		bits_next = (bits_reg & ~evt.clr) | evt.set;
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			bits_reg <= RST[W-1:0];
		else if (ce_in) begin
			if (soft_rst_in)
				bits_reg <= RST[W-1:0];
			else
				bits_reg <= bits_next;
		end
	end

	assign evt.q = bits_reg;
endmodule

/* File: src/asm_link_mon.sv */
// Link state watcher that reports a not-yet-transferring link
`timescale 1ns/1ps
module asm_link_mon (
	input  wire logic     mclk_in,
	input  wire logic     reset_n_in,
	input  wire logic     ce_in,
	input  wire logic     link_en_in,
	input  wire logic     enc_64b_in,
	input  wire logic     payload_in,
	input  wire logic     realign_in,
	output logic          alarm_out
);
	asm_pkg::asm_link_t state_reg;
	asm_pkg::asm_link_t state_next;
	logic               start_pulse;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			asm_pkg::ASM_LINK_OFF:  if (link_en_in) state_next = asm_pkg::ASM_LINK_UP;
			asm_pkg::ASM_LINK_UP:   if (!link_en_in) state_next = asm_pkg::ASM_LINK_OFF;
			                        else state_next = asm_pkg::ASM_LINK_DATA;
			asm_pkg::ASM_LINK_DATA: if (!link_en_in) state_next = asm_pkg::ASM_LINK_OFF;
			default:                state_next = asm_pkg::ASM_LINK_OFF;
		endcase
	end

	assign start_pulse = (state_reg == asm_pkg::ASM_LINK_UP);

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			state_reg <= asm_pkg::ASM_LINK_OFF;
		else if (ce_in)
			state_reg <= state_next;
	end

	// 64B/66B has no payload state, so start-up and realignment stand in for it
	always_comb begin
		if (enc_64b_in)
			alarm_out = link_en_in && (start_pulse || realign_in);
		else
			alarm_out = link_en_in && !payload_in;
	end
endmodule

/* File: tb/asm_alarm_chk.sv */
// Port-side assertions for the alarm status block
`timescale 1ns/1ps
module asm_alarm_chk #(parameter int LANES = 8) (
	input wire logic             mclk_in,
	input wire logic             reset_n_in,
	input wire logic             ce_in,
	input wire logic [11:0]      addr_in,
	input wire logic [7:0]       wdata_in,
	input wire logic             wr_in,
	input wire logic             rd_in,
	input wire logic [7:0]       rdata_out,
	input wire logic             pll_unlocked_in,
	input wire logic [LANES-1:0] lane_fifo_err_in,
	input wire logic [LANES-1:0] lane_active_in,
	input wire logic             alarm_irq_out,
	input wire logic             serial_link_enable_out
);
	wire rs = ce_in && rd_in && addr_in == asm_pkg::OFS_STATUS;
	wire rl = ce_in && rd_in && addr_in == asm_pkg::OFS_LANE;
	wire rm = ce_in && rd_in && addr_in == asm_pkg::OFS_MASK;
	wire ra = ce_in && rd_in && addr_in == asm_pkg::OFS_ALARM;
	wire wm = ce_in && wr_in && addr_in == asm_pkg::OFS_MASK;
	wire wc = ce_in && wr_in && addr_in == asm_pkg::OFS_CTRL;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	pll_set_a: assert property ((ce_in && pll_unlocked_in) ##1 rs |=> rdata_out[4]) else $error("pll alarm");
	sum_set_a: assert property ((ce_in && |(lane_fifo_err_in & lane_active_in)) ##1 rs |=> rdata_out[5])
		else $error("fifo summary alarm");
	lane_set_a: assert property (ce_in ##1 rl |=> (rdata_out & $past(lane_fifo_err_in, 2)) == $past(lane_fifo_err_in, 2))
		else $error("lane alarm");
	stat_rsvd_a: assert property (rs |=> rdata_out[1] && rdata_out[7:6] == 2'b00) else $error("status reserved");
	agg_rsvd_a: assert property (ra |=> rdata_out[7:1] == 7'h00) else $error("alarm reserved");
	mask_rw_a: assert property (wm ##1 !wr_in ##1 rm |=> rdata_out == $past(wdata_in, 3)) else $error("mask readback");
	link_en_a: assert property (wc ##1 ce_in |=> serial_link_enable_out == $past(wdata_in[0], 2))
		else $error("link enable");
	irq_mask_a: assert property (wm && wdata_in == 8'h3F ##1 ce_in |=> !alarm_irq_out) else $error("masked irq");
	cover property (rs ##1 rdata_out[4]);
	cover property ($rose(alarm_irq_out));
	cover property (wc && wdata_in[7]);
endmodule
bind asm_alarm_top asm_alarm_chk #(.LANES(LANES)) chk_u (.mclk_in, .reset_n_in, .ce_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .pll_unlocked_in, .lane_fifo_err_in, .lane_active_in, .alarm_irq_out,
	.serial_link_enable_out);

/* File: tb/tb_asm_alarm_top.sv */
// Register-level bench for the alarm status block
`timescale 1ns/1ps
module tb_asm_alarm_top;
	logic        mclk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [11:0] addr_in = 12'h000;
	logic [7:0]  wdata_in = 8'h00;
	logic [7:0]  ev = 8'h00;
	logic [7:0]  lerr = 8'h00;
	logic [7:0]  rdata_out;
	logic        irq;
	logic        pin;
	logic        link_en;
	logic        ce = 1'b1;
	int          mismatches = 0;
	int          comparisons = 0;
	asm_alarm_top dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pll_unlocked_in(ev[4]),
		.payload_state_in(!ev[3]), .serdes_realign_in(ev[1]), .sysref_realign_in(ev[2]), .div_ab_ne_cd_in(ev[0]),
		.lane_fifo_err_in(lerr | {7'h00, ev[5]}), .lane_active_in(8'h0F), .cal_done_in(1'b0),
		.alarm_irq_out(irq), .cal_status_pin_out(pin), .serial_link_enable_out(link_en));
	task automatic c(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task automatic r(input logic [11:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 c(rdata_out, e);
	endtask
	// Events are held until the next call, so reads see them still active
	task automatic p(input logic [7:0] e, input logic [7:0] l);
		@(posedge mclk_in);
		ev <= e;
		lerr <= l;
		repeat (2) @(posedge mclk_in);
		#1;
	endtask
	task automatic test_done;
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial forever #5 mclk_in = ~mclk_in;
	initial begin
		repeat (5000) @(posedge mclk_in);
		mismatches++;
		test_done;
	end
	initial begin
		repeat (3) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		r(12'h2C1, 8'h3F);
		r(12'h2C2, 8'h3F);
		r(12'h2C4, 8'hFF);
		r(12'h2C0, 8'h00);
		r(12'h2C3, 8'h00);
		w(12'h2C1, 8'h00);
		r(12'h2C1, 8'h3F);
		// Clear only after the link runs, since earlier alarms mean nothing
		w(12'h2C6, 8'h05);
		w(12'h2C1, 8'hFF);
		w(12'h2C4, 8'hFF);
		r(12'h2C1, 8'h02);
		r(12'h2C4, 8'h00);
		c({7'h00, link_en}, 8'h01);
		for (int b = 0; b < 6; b++) begin
			if (b != 1) begin
				w(12'h2C2, 8'h02 | (8'h01 << b));
				p(8'h01 << b, 8'h00);
				c({7'h00, irq}, 8'h00);
				r(12'h2C1, 8'h02 | (8'h01 << b));
				p(8'h00, 8'h00);
				w(12'h2C2, 8'h02);
				r(12'h2C0, 8'h01);
				c({6'h00, pin, irq}, 8'h03);
				w(12'h2C2, 8'h3F);
				r(12'h2C2, 8'h3F);
				c({6'h00, pin, irq}, 8'h00);
				w(12'h2C1, 8'h01 << b);
				r(12'h2C1, 8'h02);
			end
		end
		// Events while the clock enable is low must leave no trace
		@(posedge mclk_in);
		ce <= 1'b0;
		p(8'h10, 8'h00);
		p(8'h00, 8'h00);
		@(posedge mclk_in);
		ce <= 1'b1;
		r(12'h2C1, 8'h02);
		p(8'h00, 8'h20);
		r(12'h2C1, 8'h02);
		p(8'h00, 8'h02);
		r(12'h2C1, 8'h22);
		w(12'h2C4, 8'h20);
		r(12'h2C4, 8'h02);
		p(8'h00, 8'h08);
		w(12'h2C4, 8'h08);
		r(12'h2C4, 8'h0A);
		p(8'h00, 8'h00);
		w(12'h2C1, 8'h20);
		r(12'h2C4, 8'h00);
		w(12'h2C6, 8'h02);
		w(12'h2C1, 8'hFF);
		w(12'h2C6, 8'h03);
		// Start-up alarm lands two cycles after the enable is written
		p(8'h00, 8'h00);
		r(12'h2C1, 8'h0A);
		w(12'h2C1, 8'h08);
		p(8'h02, 8'h00);
		r(12'h2C1, 8'h0A);
		// An open mask and a cleared lane register show that the soft reset restores them
		w(12'h2C2, 8'h02);
		r(12'h2C0, 8'h01);
		c({6'h00, pin, irq}, 8'h01);
		w(12'h2C6, 8'h80);
		r(12'h2C1, 8'h3F);
		r(12'h2C2, 8'h3F);
		r(12'h2C4, 8'hFF);
		c({5'h00, link_en, pin, irq}, 8'h00);
		test_done;
	end
endmodule
